//--- logic/phev_pkg.sv
`default_nettype none
package phev_pkg;

  localparam int CLK_PERIOD_NS = 4;

  // Register indices on the management port
  localparam logic [4:0] LINK_CONFIG_SECOND_ADDR = 5'h13;
  localparam logic [4:0] SYMBOL_ERROR_TALLY_ADDR = 5'h14;
  localparam logic [4:0] EVENT_SOURCE_FLAGS_ADDR = 5'h15;

  // Field positions in link_config_second
  localparam int CFG_PHY_ADDR_LSB = 11;
  localparam int CFG_AVG_LSB = 9;
  localparam int CFG_WARN_LSB = 6;
  localparam int CFG_FAIL_LSB = 3;
  localparam int CFG_JUMBO_BIT = 2;
  localparam int CFG_TIMEOUT_LSB = 0;

  // Reset values of the writable fields, the symbol tally and the event flags
  localparam logic [1:0] CFG_AVG_RESET = 2'h1;
  localparam logic [2:0] CFG_WARN_RESET = 3'h1;
  localparam logic [2:0] CFG_FAIL_RESET = 3'h0;
  localparam logic CFG_JUMBO_RESET = 1'b1;
  localparam logic [1:0] CFG_TIMEOUT_RESET = 2'h1;
  localparam logic [15:0] TALLY_RESET = 16'h0000;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;

  // Bit positions in event_source_flags
  localparam int EV_POWER_UP = 15;
  localparam int EV_WAKE = 14;
  localparam int EV_WAKE_REQ = 13;
  localparam int EV_LOW_POWER = 12;
  localparam int EV_INIT_ERR = 11;
  localparam int EV_LINK_FAIL = 10;
  localparam int EV_LINK_UP = 9;
  localparam int EV_SYMBOL = 8;
  localparam int EV_TRAINING = 7;
  localparam int EV_QUALITY = 6;
  localparam int EV_CONTROL = 5;
  localparam int EV_SUPPLY_LOW = 3;
  localparam int EV_SUPPLY_OK = 2;
  localparam int EV_OVERTEMP = 1;
  localparam int EV_SLEEP_ABORT = 0;

  // Flags present only on the first port
  localparam logic [15:0] FIRST_PORT_ONLY_MASK = 16'h800e;
  // Flags wiped by sleep and undervoltage state entries
  localparam logic [15:0] LINK_GROUP_MASK = 16'h0740;
  // Reserved bit reads as zero
  localparam logic [15:0] IMPLEMENTED_MASK = 16'hffef;

  // Nominal sleep request / acknowledge timeouts in ns
  localparam int SLEEP_REQ_TO0_NS = 400000;
  localparam int SLEEP_REQ_TO1_NS = 1000000;
  localparam int SLEEP_REQ_TO2_NS = 4000000;
  localparam int SLEEP_REQ_TO3_NS = 16000000;
  localparam int SLEEP_ACK_TO0_NS = 200000;
  localparam int SLEEP_ACK_TO1_NS = 500000;
  localparam int SLEEP_ACK_TO2_NS = 2000000;
  localparam int SLEEP_ACK_TO3_NS = 8000000;

endpackage : phev_pkg
`default_nettype wire

//--- logic/phev_cnt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface phev_cnt_if #(parameter int WIDTH = 16);
  logic symbol_fault_flag;
  logic in_packet;
  logic rd_clear;
  logic [WIDTH-1:0] count;
  modport counter (input symbol_fault_flag, input in_packet, input rd_clear, output count);
  modport owner (output symbol_fault_flag, output in_packet, output rd_clear, input count);
endinterface : phev_cnt_if
`default_nettype wire

//--- logic/phev_sym_counter.sv
`timescale 1ns/1ps
`default_nettype none
module phev_sym_counter #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  phev_cnt_if.counter cnt
);

  logic counted_reg;
  logic bump;
  logic [WIDTH-1:0] count_reg;

  // Inside a packet only the first bad symbol counts; idle errors each count
  assign bump = cnt.symbol_fault_flag && !(cnt.in_packet && counted_reg);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      counted_reg <= 1'b0;
    else if (!cnt.in_packet)
      counted_reg <= 1'b0;
    else if (cnt.symbol_fault_flag)
      counted_reg <= 1'b1;
  end

  // A read returns the old count and restarts; an error in that cycle is kept
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count_reg <= phev_pkg::TALLY_RESET;
    else if (cnt.rd_clear)
      count_reg <= bump ? WIDTH'(1) : '0;
    else if (bump && count_reg != '1)
      count_reg <= count_reg + WIDTH'(1);
  end

  assign cnt.count = count_reg;

  a_count_saturates: assert property (@(posedge clk) disable iff (!rst_n)
    (count_reg == '1 && !cnt.rd_clear) |=> (count_reg == '1))
    else $error("symbol tally left all-ones without a read");

  a_once_per_packet: assert property (@(posedge clk) disable iff (!rst_n)
    (cnt.in_packet && counted_reg && !cnt.rd_clear) |=> $stable(count_reg))
    else $error("symbol tally moved twice in one packet");

  a_read_clears: assert property (@(posedge clk) disable iff (!rst_n)
    (cnt.rd_clear && !cnt.symbol_fault_flag) |=> (count_reg == '0))
    else $error("symbol tally not cleared by read");

endmodule : phev_sym_counter
`default_nettype wire

//--- logic/phev_event_latch.sv
`timescale 1ns/1ps
`default_nettype none
module phev_event_latch #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] set,
  input wire logic [WIDTH-1:0] clr,
  output logic [WIDTH-1:0] flags
);

  // Set beats clear so an event landing on the clearing read is not lost
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flags <= phev_pkg::FLAGS_RESET;
    else
      flags <= (flags & ~clr) | set;
  end

  a_flag_holds: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> ((flags & ~$past(flags) & ~$past(set)) == '0
      && ($past(flags) & ~flags & ~$past(clr)) == '0
      && (flags & $past(set)) == $past(set)))
    else $error("event flag changed without set or clear");

endmodule : phev_event_latch
`default_nettype wire

//--- logic/phev_regs.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Fail-limit codes 010 to 111 pick classes B through G in order.
// - Fail-limit field is bits 5:3; 000 none (reset), 001 class A.
// - Bit 2 clear limits packets to 4 kB, set to 16 kB; resets set.
// - Bits 1:0 pick sleep request/ack timeouts 0.4/0.2 to 16/8 ms; reset 01.
// - Sixteen-bit read-only symbol tally counts invalid symbols, idle included; resets zero.
// - Tally advances at most once per received packet.
// - Tally saturates at all-ones instead of wrapping.
// - Reading the tally returns the count then clears it.
// - Disabling link control leaves the tally untouched.
// - Bits 15..12 latch on power-on, wake, wake request, low-power code.
// - Bit 11 latches on init error, bit 7 on training failure.
// - Bit 10 latches when link-up falls from good to failed.
// - Bit 9 latches when link-up rises from failed to good.
// - Bit 8 latches on any received symbol error.
// - Bit 6 latches when quality drops below warning limit with link up.
// - Bit 5 latches on a management control access error.
// - Bit 3 latches on undervoltage, bit 2 on undervoltage recovery.
// - Bit 1 latches on overtemperature; bit 4 reserved.
// - Bit 0 latches when sleep request times out back to normal.
// - Second port reads power-on, undervoltage, recovery and overtemp bits as zero.
// - Read clears wake bit; wake detection rearms only after a power transition.
// - Link, symbol and quality bits clear on sleep and undervoltage state entries.
// - Disabled enable bit masks the event pin while the flag still latches.
module phev_regs #(
  parameter bit SECOND_PORT = 1'b0,
  parameter int REQ_TO0_CYC = phev_pkg::SLEEP_REQ_TO0_NS / phev_pkg::CLK_PERIOD_NS,
  parameter int REQ_TO1_CYC = phev_pkg::SLEEP_REQ_TO1_NS / phev_pkg::CLK_PERIOD_NS,
  parameter int REQ_TO2_CYC = phev_pkg::SLEEP_REQ_TO2_NS / phev_pkg::CLK_PERIOD_NS,
  parameter int REQ_TO3_CYC = phev_pkg::SLEEP_REQ_TO3_NS / phev_pkg::CLK_PERIOD_NS,
  parameter int ACK_TO0_CYC = phev_pkg::SLEEP_ACK_TO0_NS / phev_pkg::CLK_PERIOD_NS,
  parameter int ACK_TO1_CYC = phev_pkg::SLEEP_ACK_TO1_NS / phev_pkg::CLK_PERIOD_NS,
  parameter int ACK_TO2_CYC = phev_pkg::SLEEP_ACK_TO2_NS / phev_pkg::CLK_PERIOD_NS,
  parameter int ACK_TO3_CYC = phev_pkg::SLEEP_ACK_TO3_NS / phev_pkg::CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [4:0] phy_address,
  input wire logic power_up_seen,
  input wire logic wake_detected,
  input wire logic wake_request_seen,
  input wire logic low_power_code_seen,
  input wire logic init_error,
  input wire logic link_up,
  input wire logic rx_symbol_error,
  input wire logic rx_in_packet,
  input wire logic training_error,
  input wire logic [2:0] signal_quality_index,
  input wire logic control_error,
  input wire logic supply_low,
  input wire logic supply_restored,
  input wire logic overtemp,
  input wire logic sleep_abort,
  input wire logic power_transition_done,
  input wire logic link_events_wipe,
  input wire logic [15:0] event_enable,
  output logic event_n,
  output logic [2:0] quality_fail_threshold,
  output logic [6:0] fail_class_sel,
  output logic [6:0] warn_class_sel,
  output logic [1:0] quality_averaging,
  output logic jumbo_enable,
  output logic [22:0] sleep_request_timeout_cyc,
  output logic [22:0] sleep_ack_timeout_cyc
);

  logic rst_meta_reg;
  logic rst_n;
  logic [1:0] avg_reg;
  logic [2:0] warn_reg;
  logic [2:0] fail_reg;
  logic jumbo_reg;
  logic [1:0] timeout_reg;
  logic link_up_d_reg;
  logic wake_armed_reg;
  logic rd_cfg;
  logic rd_tally;
  logic rd_flags;
  logic quality_low;
  logic [15:0] ev_set;
  logic [15:0] ev_clr;
  logic [15:0] flags;
  logic [15:0] cfg_view;
  logic [15:0] flags_view;

  phev_cnt_if #(.WIDTH(16)) cnt_bus ();

  // Class letter A..G as one-hot; code 000 selects no limit
  function automatic logic [6:0] class_onehot(input logic [2:0] code);
    class_onehot = (code == 3'h0) ? 7'h00 : 7'(7'h01 << (code - 3'h1));
  endfunction : class_onehot

  function automatic logic [22:0] pick_timeout(input logic [1:0] sel,
      input int t0, input int t1, input int t2, input int t3);
    case (sel)
      2'h0: pick_timeout = 23'(t0);
      2'h1: pick_timeout = 23'(t1);
      2'h2: pick_timeout = 23'(t2);
      default: pick_timeout = 23'(t3);
    endcase
  endfunction : pick_timeout

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  assign rd_cfg = reg_rd && reg_addr == phev_pkg::LINK_CONFIG_SECOND_ADDR;
  assign rd_tally = reg_rd && reg_addr == phev_pkg::SYMBOL_ERROR_TALLY_ADDR;
  assign rd_flags = reg_rd && reg_addr == phev_pkg::EVENT_SOURCE_FLAGS_ADDR;

  // Only the configuration word accepts writes; the other two are read-only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      avg_reg <= phev_pkg::CFG_AVG_RESET;
      warn_reg <= phev_pkg::CFG_WARN_RESET;
      fail_reg <= phev_pkg::CFG_FAIL_RESET;
      jumbo_reg <= phev_pkg::CFG_JUMBO_RESET;
      timeout_reg <= phev_pkg::CFG_TIMEOUT_RESET;
    end
    else if (reg_wr && reg_addr == phev_pkg::LINK_CONFIG_SECOND_ADDR)
    begin
      avg_reg <= reg_wdata[phev_pkg::CFG_AVG_LSB +: 2];
      warn_reg <= reg_wdata[phev_pkg::CFG_WARN_LSB +: 3];
      fail_reg <= reg_wdata[phev_pkg::CFG_FAIL_LSB +: 3];
      jumbo_reg <= reg_wdata[phev_pkg::CFG_JUMBO_BIT];
      timeout_reg <= reg_wdata[phev_pkg::CFG_TIMEOUT_LSB +: 2];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      quality_fail_threshold <= phev_pkg::CFG_FAIL_RESET;
      fail_class_sel <= 7'h00;
      warn_class_sel <= 7'h00;
      quality_averaging <= phev_pkg::CFG_AVG_RESET;
      jumbo_enable <= phev_pkg::CFG_JUMBO_RESET;
      sleep_request_timeout_cyc <= 23'h000000;
      sleep_ack_timeout_cyc <= 23'h000000;
    end
    else
    begin
      quality_fail_threshold <= fail_reg;
      fail_class_sel <= class_onehot(fail_reg);
      warn_class_sel <= class_onehot(warn_reg);
      quality_averaging <= avg_reg;
      jumbo_enable <= jumbo_reg;
      sleep_request_timeout_cyc <= pick_timeout(timeout_reg, REQ_TO0_CYC, REQ_TO1_CYC,
        REQ_TO2_CYC, REQ_TO3_CYC);
      sleep_ack_timeout_cyc <= pick_timeout(timeout_reg, ACK_TO0_CYC, ACK_TO1_CYC,
        ACK_TO2_CYC, ACK_TO3_CYC);
    end
  end

  // No link-control input reaches the tally, so disabling the link keeps it
  assign cnt_bus.symbol_fault_flag = rx_symbol_error;
  assign cnt_bus.in_packet = rx_in_packet;
  assign cnt_bus.rd_clear = rd_tally;

  phev_sym_counter #(.WIDTH(16)) u_tally (
    .clk(clk),
    .rst_n(rst_n),
    .cnt(cnt_bus.counter)
  );

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      link_up_d_reg <= 1'b0;
    else
      link_up_d_reg <= link_up;
  end

  // Wake detection stays off after a read that returns the wake flag until the power state has moved
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wake_armed_reg <= 1'b1;
    else if (power_transition_done)
      wake_armed_reg <= 1'b1;
    else if (rd_flags && flags[phev_pkg::EV_WAKE])
      wake_armed_reg <= 1'b0;
  end

  assign quality_low = warn_reg != 3'h0 && signal_quality_index < warn_reg;

  always_comb
  begin
    ev_set = 16'h0000;
    ev_set[phev_pkg::EV_POWER_UP] = power_up_seen;
    ev_set[phev_pkg::EV_WAKE] = wake_detected && wake_armed_reg;
    ev_set[phev_pkg::EV_WAKE_REQ] = wake_request_seen;
    ev_set[phev_pkg::EV_LOW_POWER] = low_power_code_seen;
    ev_set[phev_pkg::EV_INIT_ERR] = init_error;
    ev_set[phev_pkg::EV_LINK_FAIL] = link_up_d_reg && !link_up;
    ev_set[phev_pkg::EV_LINK_UP] = !link_up_d_reg && link_up;
    ev_set[phev_pkg::EV_SYMBOL] = rx_symbol_error;
    ev_set[phev_pkg::EV_TRAINING] = training_error;
    ev_set[phev_pkg::EV_QUALITY] = quality_low && link_up;
    ev_set[phev_pkg::EV_CONTROL] = control_error;
    ev_set[phev_pkg::EV_SUPPLY_LOW] = supply_low;
    ev_set[phev_pkg::EV_SUPPLY_OK] = supply_restored;
    ev_set[phev_pkg::EV_OVERTEMP] = overtemp;
    ev_set[phev_pkg::EV_SLEEP_ABORT] = sleep_abort;
    ev_set = ev_set & phev_pkg::IMPLEMENTED_MASK;
    if (SECOND_PORT)
      ev_set = ev_set & ~phev_pkg::FIRST_PORT_ONLY_MASK;
  end

  assign ev_clr = (rd_flags ? 16'hffff : 16'h0000)
    | (link_events_wipe ? phev_pkg::LINK_GROUP_MASK : 16'h0000);

  phev_event_latch #(.WIDTH(16)) u_flags (
    .clk(clk),
    .rst_n(rst_n),
    .set(ev_set),
    .clr(ev_clr),
    .flags(flags)
  );

  // Flags latch regardless of enables; only the pin is masked
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      event_n <= 1'b1;
    else
      event_n <= ~|(flags & event_enable);
  end

  assign cfg_view = {phy_address, avg_reg, warn_reg, fail_reg, jumbo_reg, timeout_reg};
  assign flags_view = flags;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (rd_cfg)
        reg_rdata <= cfg_view;
      else if (rd_tally)
        reg_rdata <= cnt_bus.count;
      else if (rd_flags)
        reg_rdata <= flags_view;
      else if (reg_rd)
        reg_rdata <= 16'h0000;
    end
  end

  a_second_port_zero: assert property (@(posedge clk) disable iff (!rst_n)
    SECOND_PORT |-> ((flags & phev_pkg::FIRST_PORT_ONLY_MASK) == 16'h0000))
    else $error("first-port-only flag set on second port");

  a_event_pin_mask: assert property (@(posedge clk) disable iff (!rst_n)
    ((flags & event_enable) == 16'h0000) |=> event_n)
    else $error("event pin asserted for masked source");

  a_link_fail_edge: assert property (@(posedge clk) disable iff (!rst_n)
    (link_up_d_reg && !link_up) |=> flags[phev_pkg::EV_LINK_FAIL])
    else $error("link fail flag missed a falling link");

  a_wake_rearm: assert property (@(posedge clk) disable iff (!rst_n)
    (!wake_armed_reg && !power_transition_done) |=> !$rose(flags[phev_pkg::EV_WAKE]))
    else $error("wake flag set while detection disarmed");

  a_write_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == phev_pkg::EVENT_SOURCE_FLAGS_ADDR && ev_set == 16'h0000
      && ev_clr == 16'h0000) |=> $stable(flags))
    else $error("write altered event flags");

  a_read_returns: assert property (@(posedge clk) disable iff (!rst_n)
    rd_flags |=> (reg_rvalid && reg_rdata == $past(flags)))
    else $error("event read did not return latched flags");

  a_wipe_group: assert property (@(posedge clk) disable iff (!rst_n)
    (link_events_wipe && (ev_set & phev_pkg::LINK_GROUP_MASK) == 16'h0000)
      |=> ((flags & phev_pkg::LINK_GROUP_MASK) == 16'h0000))
    else $error("link group flags survived state entry");

endmodule : phev_regs
`default_nettype wire

//--- verification/phev_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module phev_host_model (
  input wire logic clk,
  output logic [4:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial
  begin
    reg_addr = 5'h1f;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end

  // After a write idle address and data show the inverse of the last value; a read inverts only the address
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic ok);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    ok = reg_rvalid;
    d = reg_rdata;
  endtask : rd

  // Wake flag is untrustworthy while the supply-low flag stands
  function automatic logic [15:0] usable_flags(input logic [15:0] f);
    return f[3] ? (f & 16'hbfff) : f;
  endfunction : usable_flags
endmodule : phev_host_model
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module testbench;
  // Timeouts scaled down so long counts stay cheap to simulate
  localparam int SC = 10000;
  localparam int REQ [4] = '{phev_pkg::SLEEP_REQ_TO0_NS / SC, phev_pkg::SLEEP_REQ_TO1_NS / SC,
    phev_pkg::SLEEP_REQ_TO2_NS / SC, phev_pkg::SLEEP_REQ_TO3_NS / SC};
  localparam int ACK [4] = '{phev_pkg::SLEEP_ACK_TO0_NS / SC, phev_pkg::SLEEP_ACK_TO1_NS / SC,
    phev_pkg::SLEEP_ACK_TO2_NS / SC, phev_pkg::SLEEP_ACK_TO3_NS / SC};
  localparam int BITS [12] = '{15, 14, 13, 12, 11, 8, 7, 5, 3, 2, 1, 0};
  logic clk = 1'b0;
  logic reset_n;
  logic [4:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_wdata;
  logic [4:0] phy_address;
  logic link_up;
  logic rx_in_packet;
  logic [2:0] signal_quality_index;
  logic [15:0] event_enable;
  logic [17:0] ev;
  logic [15:0] rdata [2];
  logic rvalid [2];
  logic event_n_o [2];
  logic [2:0] qft [2];
  logic [6:0] fcs [2];
  logic [6:0] wcs [2];
  logic [1:0] qav [2];
  logic jumbo [2];
  logic [22:0] sreq [2];
  logic [22:0] sack [2];
  int errors = 0;
  int samples_checked = 0;
  int tally_exp = 0;

  always #2 clk = ~clk;

  for (genvar g = 0; g < 2; g++)
  begin : port
    phev_regs #(.SECOND_PORT(g == 1),
      .REQ_TO0_CYC(REQ[0]), .REQ_TO1_CYC(REQ[1]), .REQ_TO2_CYC(REQ[2]), .REQ_TO3_CYC(REQ[3]),
      .ACK_TO0_CYC(ACK[0]), .ACK_TO1_CYC(ACK[1]), .ACK_TO2_CYC(ACK[2]), .ACK_TO3_CYC(ACK[3])
    ) u_dut (.clk, .reset_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
      .reg_rdata(rdata[g]), .reg_rvalid(rvalid[g]), .phy_address,
      .power_up_seen(ev[15]), .wake_detected(ev[14]), .wake_request_seen(ev[13]),
      .low_power_code_seen(ev[12]), .init_error(ev[11]), .link_up,
      .rx_symbol_error(ev[8]), .rx_in_packet, .training_error(ev[7]), .signal_quality_index,
      .control_error(ev[5]), .supply_low(ev[3]), .supply_restored(ev[2]), .overtemp(ev[1]),
      .sleep_abort(ev[0]), .power_transition_done(ev[16]), .link_events_wipe(ev[17]),
      .event_enable, .event_n(event_n_o[g]), .quality_fail_threshold(qft[g]),
      .fail_class_sel(fcs[g]), .warn_class_sel(wcs[g]), .quality_averaging(qav[g]),
      .jumbo_enable(jumbo[g]), .sleep_request_timeout_cyc(sreq[g]),
      .sleep_ack_timeout_cyc(sack[g]));
  end

  phev_host_model u_host (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata(rdata[0]), .reg_rvalid(rvalid[0]));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic pulse(input int b);
    @(posedge clk);
    #1;
    ev[b] = 1'b1;
    @(posedge clk);
    #1;
    ev[b] = 1'b0;
  endtask : pulse

  // Both ports are read together; the second hides its first-port-only flags
  task automatic rdchk(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic ok;
    u_host.rd(a, d, ok);
    `CHK(ok, 1'b1)
    `CHK(rvalid[1], 1'b1)
    `CHK(d, e)
    `CHK(rdata[1], (a == 5'h15) ? (e & ~phev_pkg::FIRST_PORT_ONLY_MASK) : e)
  endtask : rdchk

  task automatic done(input string name);
    $display("Test %s done, errors %0d", name, errors);
  endtask : done

  task automatic print_verdict();
    $display("Checked %0d samples, %0d errors", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (99000) @(posedge clk);
    errors++;
    $display("Error at %0t: run did not finish", $time);
    print_verdict();
  end

  initial
  begin
    logic [15:0] w;
    int n;
    logic ok;
    reset_n = 1'b0;
    ev = '0;
    link_up = 1'b0;
    rx_in_packet = 1'b0;
    signal_quality_index = 3'h7;
    event_enable = 16'h0000;
    void'($urandom(9));
    phy_address = 5'($urandom);
    repeat (6) @(posedge clk);
    #1;
    reset_n = 1'b1;
    cyc(3);
    rdchk(5'h13, {phy_address, 11'h245});
    `CHK(jumbo[0], 1'b1)
    `CHK(sreq[0], 23'(REQ[1]))
    `CHK(sack[0], 23'(ACK[1]))
    rdchk(5'h14, 16'h0000);
    rdchk(5'h15, 16'h0000);
    rdchk(5'h1f, 16'h0000);
    done("reset");
    for (int i = 0; i < 8; i++)
    begin
      w = 16'($urandom);
      w[5:3] = 3'(i);
      w[2] = i[2];
      w[1:0] = 2'(i);
      u_host.wr(5'h13, w);
      rdchk(5'h13, {phy_address, w[10:0]});
      `CHK(fcs[0], (i == 0) ? 7'h00 : 7'(1 << (i - 1)))
      `CHK(qft[0], 3'(i))
      `CHK(qav[0], w[10:9])
      `CHK(wcs[0], (w[8:6] == 3'h0) ? 7'h00 : 7'(1 << (w[8:6] - 1)))
      `CHK(jumbo[0], w[2])
      `CHK(sreq[0], 23'(REQ[i % 4]))
      `CHK(sack[0], 23'(ACK[i % 4]))
    end
    u_host.wr(5'h14, 16'hffff);
    u_host.wr(5'h15, 16'hffff);
    rdchk(5'h14, 16'h0000);
    rdchk(5'h15, 16'h0000);
    done("config");
    foreach (BITS[k])
    begin
      w = 16'($urandom);
      w[BITS[k]] = k[0];
      event_enable = w;
      pulse(BITS[k]);
      cyc(2);
      `CHK(event_n_o[0], ~event_enable[BITS[k]])
      `CHK(event_n_o[1], ~(event_enable[BITS[k]] & ~phev_pkg::FIRST_PORT_ONLY_MASK[BITS[k]]))
      rdchk(5'h15, 16'h1 << BITS[k]);
      rdchk(5'h15, 16'h0000);
    end
    tally_exp++;
    pulse(14);
    cyc(2);
    rdchk(5'h15, 16'h0000);
    pulse(16);
    pulse(14);
    cyc(2);
    rdchk(5'h15, 16'h4000);
    // Wake seen under a supply-low flag must be discarded by the host
    pulse(16);
    pulse(3);
    pulse(14);
    cyc(1);
    u_host.rd(5'h15, w, ok);
    `CHK(w, 16'h4008)
    `CHK(u_host.usable_flags(w), 16'h0008)
    done("events");
    link_up = 1'b1;
    cyc(2);
    rdchk(5'h15, 16'h0200);
    u_host.wr(5'h13, 16'h00c5);
    signal_quality_index = 3'h1;
    cyc(2);
    signal_quality_index = 3'h3;
    rdchk(5'h15, 16'h0040);
    // Equal to the limit is not below it, so the flag must not re-latch
    rdchk(5'h15, 16'h0000);
    link_up = 1'b0;
    signal_quality_index = 3'h1;
    cyc(3);
    rdchk(5'h15, 16'h0400);
    signal_quality_index = 3'h7;
    link_up = 1'b1;
    pulse(8);
    pulse(7);
    pulse(17);
    cyc(2);
    rdchk(5'h15, 16'h0080);
    tally_exp++;
    done("link");
    rdchk(5'h14, 16'(tally_exp));
    rx_in_packet = 1'b1;
    ev[8] = 1'b1;
    cyc(3);
    ev[8] = 1'b0;
    rx_in_packet = 1'b0;
    cyc(1);
    rdchk(5'h14, 16'h0001);
    rdchk(5'h14, 16'h0000);
    n = 1 + $urandom_range(20);
    repeat (n) pulse(8);
    cyc(1);
    rdchk(5'h14, 16'(n));
    ev[8] = 1'b1;
    cyc(65540);
    ev[8] = 1'b0;
    cyc(1);
    rdchk(5'h14, 16'hffff);
    rdchk(5'h14, 16'h0000);
    done("tally");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
